/* File: rtl/cbdf_params.svh */
`ifndef CBDF_PARAMS_SVH
`define CBDF_PARAMS_SVH

// Curve selector and mask widths.
`define CBDF_MASK_W 22
`define CBDF_SEL_W 5
`define CBDF_SINGLE_MASK_W 17

// Highest curve numbers accepted by a binary dump.
`define CBDF_BIN_MAX_SINGLE 5'h10
`define CBDF_BIN_MAX_DUAL 5'h15
`define CBDF_FAST_MAX_SINGLE 5'h04
`define CBDF_FAST_MAX_DUAL 5'h07

// The frequency curve is split into a lower and an upper half.
`define CBDF_FREQ_LO 5'h0F
`define CBDF_FREQ_HI 5'h10

// Text encoding of decimal values.
`define CBDF_ASCII_ZERO 8'h30
`define CBDF_ASCII_MINUS 8'h2D
`define CBDF_DEC_DIGITS 10
`define CBDF_TOP_DIGIT 4'h9

`endif

/* File: rtl/cbdf_pkg.sv */
package cbdf_pkg;

    // Kind of dump requested by the host.
    typedef enum logic {
        cbdf_binary,
        cbdf_tabular
    } cbdf_kind_t;

    // Dump sequencer states.
    typedef enum logic [3:0] {
        st_idle,
        st_sel,
        st_delim,
        st_rd,
        st_rd1,
        st_rd2,
        st_conv,
        st_dig,
        st_bhi,
        st_blo,
        st_term
    } cbdf_state_t;

    // Decimal formatter states.
    typedef enum logic [1:0] {
        dq_idle,
        dq_sign,
        dq_digit
    } cbdf_dec_state_t;

endpackage

/* File: rtl/cbdf_dec_fmt.sv */
`timescale 1ns/1ns
`default_nettype none
`include "cbdf_params.svh"

module cbdf_dec_fmt
    import cbdf_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset_n,
    // Value to convert.
    input wire logic start,
    input wire logic signed [31:0] value,
    // Character stream.
    output logic ch_valid,
    output logic [7:0] ch_data,
    input wire logic ch_ready,
    output logic done
);

    cbdf_dec_state_t state_q;
    logic [31:0] mag_q;
    logic [3:0] pidx_q;
    logic [3:0] dig_q;
    logic started_q;
    logic ch_valid_q;
    logic [7:0] ch_data_q;
    logic done_q;
    logic [31:0] pw;

    // Power of ten for the digit position being produced.
    function automatic logic [31:0] pow10(input logic [3:0] idx);
        logic [31:0] p;
        p = 32'h00000001;
        for (int i = 0; i < `CBDF_DEC_DIGITS; i++)
        begin
            if (i < idx)
            begin
                p = p * 32'h0000000A;
            end
        end
        return p;
    endfunction

    assign pw = pow10(pidx_q);
    assign ch_valid = ch_valid_q;
    assign ch_data = ch_data_q;
    assign done = done_q;

    // Digits come out by repeated subtraction, most significant first, with
    // leading zeros suppressed; a lone zero is still sent.
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= dq_idle;
            mag_q <= 32'h00000000;
            pidx_q <= 4'h0;
            dig_q <= 4'h0;
            started_q <= 1'b0;
            ch_valid_q <= 1'b0;
            ch_data_q <= 8'h00;
            done_q <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            case (state_q)
                dq_idle:
                begin
                    if (start)
                    begin
                        mag_q <= value[31] ? 32'(-value) : 32'(value);
                        pidx_q <= `CBDF_TOP_DIGIT;
                        dig_q <= 4'h0;
                        started_q <= 1'b0;
                        ch_valid_q <= value[31];
                        ch_data_q <= `CBDF_ASCII_MINUS;
                        state_q <= value[31] ? dq_sign : dq_digit;
                    end
                end
                dq_sign:
                begin
                    if (ch_ready)
                    begin
                        ch_valid_q <= 1'b0;
                        state_q <= dq_digit;
                    end
                end
                dq_digit:
                begin
                    if (ch_valid_q)
                    begin
                        if (ch_ready)
                        begin
                            ch_valid_q <= 1'b0;
                            dig_q <= 4'h0;
                            if (pidx_q == 4'h0)
                            begin
                                done_q <= 1'b1;
                                state_q <= dq_idle;
                            end
                            else
                            begin
                                pidx_q <= pidx_q - 4'h1;
                            end
                        end
                    end
                    else if (mag_q >= pw)
                    begin
                        mag_q <= mag_q - pw;
                        dig_q <= dig_q + 4'h1;
                    end
                    else if (dig_q != 4'h0 || started_q || pidx_q == 4'h0)
                    begin
                        started_q <= 1'b1;
                        ch_valid_q <= 1'b1;
                        ch_data_q <= `CBDF_ASCII_ZERO + {4'h0, dig_q};
                    end
                    else
                    begin
                        pidx_q <= pidx_q - 4'h1;
                    end
                end
                default:
                begin
                    state_q <= dq_idle;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

/* File: rtl/cbdf_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "cbdf_params.svh"

module cbdf_top
    import cbdf_pkg::*;
#(
    parameter int PT_W = 17
)
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset_n,
    // Dump command.
    input wire logic cmd_valid,
    input wire logic cmd_tabular,
    input wire logic [`CBDF_MASK_W-1:0] cmd_arg,
    // Buffer configuration.
    input wire logic fast_mode,
    input wire logic dual_mode,
    input wire logic [`CBDF_MASK_W-1:0] stored_mask,
    input wire logic [PT_W-1:0] curve_len,
    input wire logic [7:0] delim_char,
    input wire logic [7:0] term_char,
    // Curve buffer read port.
    output logic mem_rd_en,
    output logic [`CBDF_SEL_W-1:0] mem_curve,
    output logic [PT_W-1:0] mem_addr,
    input wire logic [15:0] mem_rd_data,
    // Response byte stream.
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    // Status.
    output logic busy,
    output logic param_err,
    output logic dump_done
);

    if (PT_W < 1 || PT_W > 30)
    begin : g_chk
        $error("cbdf_top: PT_W out of range");
    end

    cbdf_state_t state_q;
    cbdf_kind_t kind_q;
    logic [`CBDF_MASK_W-1:0] sel_q;
    logic [PT_W-1:0] len_q;
    logic [PT_W-1:0] pt_q;
    logic [`CBDF_SEL_W-1:0] bit_q;
    logic first_q;
    logic hi_phase_q;
    logic [15:0] word_q;
    logic [15:0] lo_q;
    logic [7:0] delim_q;
    logic [7:0] term_q;
    logic busy_q;
    logic err_q;
    logic done_q;
    logic tx_valid_q;
    logic [7:0] tx_data_q;
    logic mem_rd_en_q;
    logic [`CBDF_SEL_W-1:0] mem_curve_q;
    logic [PT_W-1:0] mem_addr_q;
    logic [PT_W:0] bin_bytes_q;
    logic tx_free;
    logic last_pt;
    logic [`CBDF_SEL_W-1:0] arg_sel;
    logic bin_ok;
    logic tab_ok;
    logic nsel_found;
    logic [`CBDF_SEL_W-1:0] nsel_idx;
    logic conv_valid;
    logic [7:0] conv_char;
    logic conv_done;
    logic conv_ready;
    logic signed [31:0] conv_value;

    // Lowest selected curve at or above a position; the upper frequency half
    // is never a column of its own.
    function automatic logic [`CBDF_SEL_W:0] next_sel(input logic [`CBDF_MASK_W-1:0] m,
                                                     input logic [`CBDF_SEL_W-1:0] from);
        logic [`CBDF_SEL_W:0] r;
        r = '0;
        for (int i = `CBDF_MASK_W - 1; i >= 0; i--)
        begin
            if (m[i] && i >= int'(from) && i != int'(`CBDF_FREQ_HI))
            begin
                r = {1'b1, `CBDF_SEL_W'(i)};
            end
        end
        return r;
    endfunction

    assign tx_free = !tx_valid_q || tx_ready;
    assign last_pt = (pt_q == len_q - PT_W'(1));
    assign arg_sel = cmd_arg[`CBDF_SEL_W-1:0];
    assign {nsel_found, nsel_idx} = next_sel(sel_q, bit_q);

    // Binary requests: fast selector range or a stored standard curve.
    assign bin_ok = (cmd_arg[`CBDF_MASK_W-1:`CBDF_SEL_W] == '0) && (fast_mode ?
        (arg_sel <= (dual_mode ? `CBDF_FAST_MAX_DUAL : `CBDF_FAST_MAX_SINGLE)) :
        (arg_sel <= (dual_mode ? `CBDF_BIN_MAX_DUAL : `CBDF_BIN_MAX_SINGLE)
         && stored_mask[arg_sel]));

    // Tabular requests: standard mode, nonzero mask of stored curves only.
    assign tab_ok = !fast_mode
        && (cmd_arg != '0)
        && (dual_mode || cmd_arg[`CBDF_MASK_W-1:`CBDF_SINGLE_MASK_W] == '0)
        && ((cmd_arg & ~stored_mask) == '0);

    // Frequency joins its halves; other curves are signed 16-bit values.
    assign conv_value = (bit_q == `CBDF_FREQ_LO) ? signed'({word_q, lo_q})
        : 32'(signed'(word_q));
    assign conv_ready = (state_q == st_dig) && tx_free;

    // Decimal text for tabular values.
    cbdf_dec_fmt u_dec (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .start(state_q == st_conv),
        .value(conv_value),
        .ch_valid(conv_valid),
        .ch_data(conv_char),
        .ch_ready(conv_ready),
        .done(conv_done)
    );

    // Dump sequencer: command check, point walk and curve walk.
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= st_idle;
            kind_q <= cbdf_binary;
            sel_q <= '0;
            len_q <= '0;
            pt_q <= '0;
            bit_q <= '0;
            first_q <= 1'b0;
            hi_phase_q <= 1'b0;
            word_q <= 16'h0000;
            lo_q <= 16'h0000;
            delim_q <= 8'h00;
            term_q <= 8'h00;
            busy_q <= 1'b0;
            err_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            err_q <= 1'b0;
            done_q <= 1'b0;
            case (state_q)
                st_idle:
                begin
                    if (cmd_valid)
                    begin
                        len_q <= curve_len;
                        delim_q <= delim_char;
                        term_q <= term_char;
                        pt_q <= '0;
                        first_q <= 1'b1;
                        hi_phase_q <= 1'b0;
                        sel_q <= cmd_arg;
                        kind_q <= cmd_tabular ? cbdf_tabular : cbdf_binary;
                        bit_q <= cmd_tabular ? '0 : arg_sel;
                        if (curve_len != '0 && (cmd_tabular ? tab_ok : bin_ok))
                        begin
                            busy_q <= 1'b1;
                            state_q <= cmd_tabular ? st_sel : st_rd;
                        end
                        else
                        begin
                            err_q <= 1'b1;
                        end
                    end
                end
                st_sel:
                begin
                    if (nsel_found)
                    begin
                        bit_q <= nsel_idx;
                        state_q <= first_q ? st_rd : st_delim;
                    end
                    else
                    begin
                        state_q <= st_term;
                    end
                end
                st_delim:
                begin
                    state_q <= tx_free ? st_rd : st_delim;
                end
                st_rd:
                begin
                    state_q <= st_rd1;
                end
                st_rd1:
                begin
                    state_q <= st_rd2;
                end
                st_rd2:
                begin
                    if (kind_q == cbdf_binary)
                    begin
                        word_q <= mem_rd_data;
                        state_q <= st_bhi;
                    end
                    else if (bit_q == `CBDF_FREQ_LO && !hi_phase_q)
                    begin
                        lo_q <= mem_rd_data;
                        hi_phase_q <= 1'b1;
                        state_q <= st_rd;
                    end
                    else
                    begin
                        word_q <= mem_rd_data;
                        hi_phase_q <= 1'b0;
                        state_q <= st_conv;
                    end
                end
                st_conv:
                begin
                    state_q <= st_dig;
                end
                st_dig:
                begin
                    if (conv_done)
                    begin
                        first_q <= 1'b0;
                        bit_q <= bit_q + `CBDF_SEL_W'(1);
                        state_q <= st_sel;
                    end
                end
                st_bhi:
                begin
                    state_q <= tx_free ? st_blo : st_bhi;
                end
                st_blo:
                begin
                    if (tx_free)
                    begin
                        pt_q <= last_pt ? pt_q : pt_q + PT_W'(1);
                        state_q <= last_pt ? st_term : st_rd;
                    end
                end
                st_term:
                begin
                    if (tx_free)
                    begin
                        if (kind_q == cbdf_binary || last_pt)
                        begin
                            busy_q <= 1'b0;
                            done_q <= 1'b1;
                            state_q <= st_idle;
                        end
                        else
                        begin
                            pt_q <= pt_q + PT_W'(1);
                            bit_q <= '0;
                            first_q <= 1'b1;
                            state_q <= st_sel;
                        end
                    end
                end
                default:
                begin
                    state_q <= st_idle;
                end
            endcase
        end
    end

    // Response byte register: bytes, delimiters, digits and terminators.
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tx_valid_q <= 1'b0;
            tx_data_q <= 8'h00;
        end
        else if (tx_free)
        begin
            tx_valid_q <= 1'b1;
            case (state_q)
                st_bhi: tx_data_q <= word_q[15:8];
                st_blo: tx_data_q <= word_q[7:0];
                st_delim: tx_data_q <= delim_q;
                st_term: tx_data_q <= term_q;
                st_dig:
                begin
                    tx_valid_q <= conv_valid;
                    tx_data_q <= conv_char;
                end
                default: tx_valid_q <= 1'b0;
            endcase
        end
    end

    // Curve buffer read request, one cycle per word.
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mem_rd_en_q <= 1'b0;
            mem_curve_q <= '0;
            mem_addr_q <= '0;
        end
        else
        begin
            mem_rd_en_q <= (state_q == st_rd);
            if (state_q == st_rd)
            begin
                mem_curve_q <= hi_phase_q ? `CBDF_FREQ_HI : bit_q;
                mem_addr_q <= pt_q;
            end
        end
    end

    // Binary byte tally, read only by the checks below.
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bin_bytes_q <= '0;
        end
        else if (state_q == st_idle)
        begin
            bin_bytes_q <= '0;
        end
        else if ((state_q == st_bhi || state_q == st_blo) && tx_free)
        begin
            bin_bytes_q <= bin_bytes_q + (PT_W+1)'(1);
        end
    end

    assign tx_valid = tx_valid_q;
    assign tx_data = tx_data_q;
    assign mem_rd_en = mem_rd_en_q;
    assign mem_curve = mem_curve_q;
    assign mem_addr = mem_addr_q;
    assign busy = busy_q;
    assign param_err = err_q;
    assign dump_done = done_q;

    // Checks tying stream contents and request handling to their causes.
    a_msb_first: assert property (@(posedge ref_clk) disable iff (!reset_n)
        state_q == st_bhi && tx_free |=> tx_valid_q && tx_data_q == word_q[15:8]
        ##1 (tx_data_q == $past(word_q[7:0]) || !tx_valid_q || state_q == st_blo))
        else $error("binary high byte not sent first");
    a_lsb_second: assert property (@(posedge ref_clk) disable iff (!reset_n)
        state_q == st_blo && tx_free |=> tx_data_q == $past(word_q[7:0]))
        else $error("binary low byte wrong");
    a_byte_count: assert property (@(posedge ref_clk) disable iff (!reset_n)
        state_q == st_term && kind_q == cbdf_binary |-> bin_bytes_q == {len_q, 1'b0})
        else $error("binary byte count is not twice the length");
    a_term_last: assert property (@(posedge ref_clk) disable iff (!reset_n)
        state_q == st_term && kind_q == cbdf_binary
        |-> last_pt && ($past(state_q) == st_blo || $past(state_q) == st_term))
        else $error("terminator inside binary block");
    a_fast_refuse: assert property (@(posedge ref_clk) disable iff (!reset_n)
        state_q == st_idle && cmd_valid && cmd_tabular && fast_mode
        |=> param_err && state_q == st_idle)
        else $error("tabular dump taken in fast mode");
    a_unstored_err: assert property (@(posedge ref_clk) disable iff (!reset_n)
        state_q == st_idle && cmd_valid && !cmd_tabular && !fast_mode
        && arg_sel <= `CBDF_BIN_MAX_SINGLE && !stored_mask[arg_sel] |=> param_err)
        else $error("unstored curve not refused");
    a_mask_omit: assert property (@(posedge ref_clk) disable iff (!reset_n)
        mem_rd_en_q && kind_q == cbdf_tabular && mem_curve_q != `CBDF_FREQ_HI
        |-> sel_q[mem_curve_q])
        else $error("unselected curve read");
    a_freq_pair: assert property (@(posedge ref_clk) disable iff (!reset_n)
        mem_rd_en_q && kind_q == cbdf_tabular && mem_curve_q == `CBDF_FREQ_LO
        |=> ##2 mem_rd_en_q && mem_curve_q == `CBDF_FREQ_HI)
        else $error("frequency upper half not read");
    a_delim_char: assert property (@(posedge ref_clk) disable iff (!reset_n)
        state_q == st_delim && tx_free |=> tx_valid_q && tx_data_q == delim_q)
        else $error("delimiter not sent");
    a_ascending: assert property (@(posedge ref_clk) disable iff (!reset_n)
        state_q == st_sel && nsel_found |-> nsel_idx >= bit_q)
        else $error("curves out of ascending order");

endmodule
`default_nettype wire

/* File: dv/cbdf_curve_mem.sv */
`timescale 1ns/1ns
`default_nettype none

module cbdf_curve_mem
#(
    parameter int PT_W = 17
)
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset_n,
    // Curve buffer read port.
    input wire logic mem_rd_en,
    input wire logic [4:0] mem_curve,
    input wire logic [PT_W-1:0] mem_addr,
    output logic [15:0] mem_rd_data
);
    // Stored word of a curve point; curve 1 is negative, curve 15 uses the top bit.
    function automatic logic [15:0] word(input int c, input int a);
        if (c == 1)
            return 16'(-7 * (a + 1));
        if (c == 15)
            return 16'(32'hFFF0 + a);
        if (c == 16)
            return 16'h0002;
        return 16'(c * 256 + a);
    endfunction

    logic [15:0] word_q;
    logic [1:0] live_q;

    // Captures the addressed word and tracks the two-cycle answer window.
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            word_q <= '0;
            live_q <= 2'h0;
        end
        else
        begin
            live_q <= {live_q[0], mem_rd_en};
            if (mem_rd_en)
                word_q <= word(int'(mem_curve), int'(mem_addr));
        end
    end

    // Outside the window the data lines show the inverse, so a late sample is caught.
    assign mem_rd_data = (live_q != 2'h0) ? word_q : ~word_q;
endmodule

`default_nettype wire

/* File: dv/test_curve_buffer_dump_formatter.sv */
`timescale 1ns/1ns
`default_nettype none
`include "cbdf_params.svh"

module test_curve_buffer_dump_formatter;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic cmd_valid = 1'b0;
    logic cmd_tabular = 1'b0;
    logic [21:0] cmd_arg = '0;
    logic [21:0] stored_mask = '0;
    logic fast_mode = 1'b0;
    logic dual_mode = 1'b0;
    logic [16:0] curve_len = 17'h00003;
    logic [7:0] delim_char = 8'h2C;
    logic [7:0] term_char = 8'h0D;
    logic tx_ready = 1'b1;
    logic stall = 1'b0;
    logic mem_rd_en, tx_valid, busy, param_err, dump_done;
    logic [4:0] mem_curve;
    logic [16:0] mem_addr;
    logic [15:0] mem_rd_data;
    logic [7:0] tx_data;
    logic [7:0] rx[$];
    logic [7:0] exp[$];
    int n_mismatch = 0;
    int checked = 0;

    cbdf_top #(.PT_W(17)) dut (.ref_clk(ref_clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
        .cmd_tabular(cmd_tabular), .cmd_arg(cmd_arg), .fast_mode(fast_mode),
        .dual_mode(dual_mode), .stored_mask(stored_mask), .curve_len(curve_len),
        .delim_char(delim_char), .term_char(term_char), .mem_rd_en(mem_rd_en),
        .mem_curve(mem_curve), .mem_addr(mem_addr), .mem_rd_data(mem_rd_data),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .busy(busy),
        .param_err(param_err), .dump_done(dump_done));

    cbdf_curve_mem #(.PT_W(17)) u_mem (.ref_clk(ref_clk), .reset_n(reset_n),
        .mem_rd_en(mem_rd_en), .mem_curve(mem_curve), .mem_addr(mem_addr),
        .mem_rd_data(mem_rd_data));

    // Free-running clock.
    always #25 ref_clk = ~ref_clk;

    // Host sink collects every byte taken and stalls on alternate cycles when asked.
    always @(posedge ref_clk)
    begin
        if (tx_valid === 1'b1 && tx_ready)
            rx.push_back(tx_data);
        tx_ready <= stall ? ~tx_ready : 1'b1;
    end

    task automatic check(input string what, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("Error %s expected %0h seen %0h", what, e, s);
        end
    endtask

    task automatic results();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Sets the buffer configuration and lets it settle.
    task automatic cfg(input logic f, input logic d, input logic [21:0] m, input logic [7:0] dl);
        @(posedge ref_clk);
        fast_mode <= f;
        dual_mode <= d;
        stored_mask <= m;
        delim_char <= dl;
        #1;
    endtask

    task automatic push_dec(input int v);
        int d[$];
        if (v < 0)
        begin
            exp.push_back(8'h2D);
            v = -v;
        end
        do
        begin
            d.push_front(v % 10);
            v = v / 10;
        end while (v > 0);
        foreach (d[i])
            exp.push_back(8'h30 + 8'(d[i]));
    endtask

    task automatic exp_bin(input int c, input int len);
        logic [15:0] w;
        exp.delete();
        for (int a = 0; a < len; a++)
        begin
            w = u_mem.word(c, a);
            exp.push_back(w[15:8]);
            exp.push_back(w[7:0]);
        end
        exp.push_back(term_char);
    endtask

    task automatic exp_tab(input logic [21:0] m, input int len);
        logic [15:0] w;
        bit first;
        for (int a = 0; a < len; a++)
        begin
            first = 1'b1;
            for (int b = 0; b < 22; b++)
            begin
                if (m[b] && b != 16)
                begin
                    if (!first)
                        exp.push_back(delim_char);
                    first = 1'b0;
                    w = u_mem.word(b, a);
                    if (b == 15)
                        push_dec(65536 * int'($signed(u_mem.word(16, a))) + int'(w));
                    else
                        push_dec(int'($signed(w)));
                end
            end
            exp.push_back(term_char);
        end
    endtask

    // Issues one dump request and judges the answer against exp.
    task automatic dump(input logic tab, input logic [21:0] arg, input logic bad);
        int n;
        rx.delete();
        @(posedge ref_clk);
        cmd_tabular <= tab;
        cmd_arg <= arg;
        cmd_valid <= 1'b1;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        #1;
        check("param_err", 32'(bad), 32'(param_err));
        check("busy", 32'(!bad), 32'(busy));
        n = 0;
        while (!bad && dump_done !== 1'b1 && n < 5000)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (!bad)
        begin
            check("dump_done", 32'h1, 32'(dump_done));
            // The terminator is still in the output register; let the sink take it.
            repeat (2) @(posedge ref_clk);
            #1;
            check("rx length", exp.size(), rx.size());
            foreach (exp[i])
                if (i < rx.size())
                    check("rx byte", 32'(exp[i]), 32'(rx[i]));
        end
    endtask

    task automatic t_binary();
        cfg(1'b0, 1'b0, 22'h018006, 8'h2C);
        exp_bin(2, 3);
        dump(1'b0, 22'h000002, 1'b0);
        exp_bin(1, 3);
        dump(1'b0, 22'h000001, 1'b0);
        exp_bin(15, 3);
        dump(1'b0, 22'h00000F, 1'b0);
        exp_bin(16, 3);
        dump(1'b0, 22'h000010, 1'b0);
        cfg(1'b0, 1'b1, 22'h3FFFFF, 8'h2C);
        exp_bin(21, 3);
        dump(1'b0, 22'h000015, 1'b0);
    endtask

    task automatic t_fast();
        cfg(1'b1, 1'b0, 22'h000000, 8'h2C);
        for (int s = 0; s < 5; s++)
        begin
            exp_bin(s, 3);
            dump(1'b0, 22'(s), 1'b0);
        end
        dump(1'b0, 22'h000005, 1'b1);
        dump(1'b1, 22'h000006, 1'b1);
        cfg(1'b1, 1'b1, 22'h000000, 8'h2C);
        for (int s = 5; s < 8; s++)
        begin
            exp_bin(s, 3);
            dump(1'b0, 22'(s), 1'b0);
        end
        dump(1'b0, 22'h000008, 1'b1);
    endtask

    task automatic t_refuse();
        cfg(1'b0, 1'b0, 22'h018006, 8'h2C);
        dump(1'b0, 22'h000003, 1'b1);
        dump(1'b0, 22'h000011, 1'b1);
        dump(1'b0, 22'h000022, 1'b1);
        dump(1'b1, 22'h000000, 1'b1);
        dump(1'b1, 22'h000009, 1'b1);
        cfg(1'b0, 1'b0, 22'h3FFFFF, 8'h2C);
        dump(1'b1, 22'h020002, 1'b1);
        curve_len <= 17'h00000;
        dump(1'b0, 22'h000002, 1'b1);
        curve_len <= 17'h00003;
    endtask

    task automatic t_tabular();
        cfg(1'b0, 1'b0, 22'h3FFFFF, 8'h2C);
        exp.delete();
        exp_tab(22'h00C006, 3);
        dump(1'b1, 22'h00C006, 1'b0);
        cfg(1'b0, 1'b0, 22'h3FFFFF, 8'h20);
        exp.delete();
        exp_tab(22'h010081, 3);
        dump(1'b1, 22'h010081, 1'b0);
        cfg(1'b0, 1'b1, 22'h3FFFFF, 8'h3B);
        exp.delete();
        exp_tab(22'h220002, 3);
        dump(1'b1, 22'h220002, 1'b0);
    endtask

    task automatic t_stall();
        cfg(1'b0, 1'b0, 22'h3FFFFF, 8'h2C);
        stall <= 1'b1;
        exp.delete();
        exp_tab(22'h008002, 3);
        dump(1'b1, 22'h008002, 1'b0);
        exp_bin(2, 3);
        dump(1'b0, 22'h000002, 1'b0);
        stall <= 1'b0;
    endtask

    // Cuts a hung run short; all scenarios need well under this span.
    initial
    begin
        #(60000 * 50);
        n_mismatch++;
        $display("Error watchdog expected finish seen timeout");
        results();
    end

    // Main sequence.
    initial
    begin
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_binary();
        t_fast();
        t_refuse();
        t_tabular();
        t_stall();
        results();
    end
endmodule

`default_nettype wire
